/* verilog/jsaseq_core.sv */
/*
   Sequencer for relative jump, jump-to-subroutine and auto-index addressing.
   Holds a small 16-word memory field model in flip-flops standing in for main
   memory, so that software can load words and run one instruction.
   Assumes an APB master on pclk; no other clock.
*/
`timescale 1ns/100ps
module jsaseq_core
   import jsaseq_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire jsaseq_pkg::jsaseq_apb_req_t apb_req,
   output      jsaseq_pkg::jsaseq_apb_rsp_t apb_rsp,
   output      logic [11:0]             pc_out,
   output      logic                    busy_out
);
   import jsaseq_pkg::*;

   // ****************************************************************
   // State
   // ****************************************************************
   typedef enum logic [3:0] {
      S_IDLE, S_FETCH, S_WB, S_DECODE, S_BP4, S_BP5, S_PTR, S_PTRWB,
      S_EP0, S_EXEC_PERIOD_3, S_EP5, S_EXEC_PERIOD_6, S_PULSE_7
   } jsaseq_step_t;

   typedef struct packed {
      jsaseq_step_t        step;
      jsaseq_phase_t       phase;
      logic [11:0]         pc;
      logic [11:0]         cur_addr;
      logic [11:0]         instr;
      logic [11:0]         buf_word;
      logic [11:0]         data_word;
      logic                done;
      logic                indirect_latch;
      logic                indirect_flipflop_latch;
      logic                autoindex_locator_latch;
      logic                basic_phase_latch;
      logic                tw;
      logic                exec_cond;
      logic                err;
      logic [7:0]          tick;
      logic [11:0]         sw_addr;
      logic [11:0]         mem_waddr;
      logic [11:0]         mem_wdata;
      logic                mem_we;
      jsaseq_apb_rsp_t     rsp;
      logic                busy;
   } jsaseq_state_t;

   jsaseq_state_t state_reg;
   jsaseq_state_t state_next;
   logic [11:0]   mem_reg [0:15];

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic [11:0] add_word(input logic [11:0] a, input logic [11:0] b,
                                            input logic sub, input logic cin);
      logic [11:0] bb;
      bb = sub ? ~b : b;
      return 12'(a + bb + {11'h000, (sub | cin)});
   endfunction

   function automatic logic [11:0] rel_addr(input logic [11:0] w);
      return {6'h00, w[5:0]};
   endfunction

   function automatic logic [11:0] mem_rd(input logic [11:0] a);
      return mem_reg[a[3:0]];
   endfunction

   logic is_jump;
   logic is_subr;
   logic bit5;
   logic indirect;
   logic autoidx;
   logic [7:0] tick_max;
   logic [11:0] mx_val;

   always_comb
   begin
      is_jump  = state_reg.instr[11:8] == OP_JUMP;
      is_subr  = (state_reg.instr[11:8] == OP_SUBR) || state_reg.tw;
      bit5     = state_reg.instr[BIT5_POS];
      indirect = state_reg.instr[BIT4_POS];
      // Two-word forms never auto-index; direct access to words 0/7777 is ordinary.
      autoidx  = indirect && !state_reg.tw && (state_reg.instr[5:0] == 6'h00);
      tick_max = 8'(PERIOD_CYCLES - 1);
      // The utility gates give all ones; with no selection the mux gives zero.
      mx_val   = bit5 ? ALL_ONES : ZERO_WORD;
   end

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      logic adv;
      adv = 1'b0;
      state_next = state_reg;
      state_next.mem_we = 1'b0;
      state_next.rsp.pready = 1'b0;
      state_next.rsp.pslverr = 1'b0;
      state_next.rsp.prdata = 32'h0000_0000;

      if (state_reg.step != S_IDLE)
      begin
         if (state_reg.tick == tick_max)
         begin
            state_next.tick = 8'h00;
            adv = 1'b1;
         end
         else
         begin
            state_next.tick = 8'(state_reg.tick + 8'h01);
         end
      end

      if (adv)
      begin
         unique case (state_reg.step)
            S_FETCH:
            begin
               state_next.cur_addr  = state_reg.pc;
               state_next.buf_word  = mem_rd(state_reg.pc);
               state_next.data_word = mem_rd(state_reg.pc);
               state_next.instr     = mem_rd(state_reg.pc);
               state_next.done      = 1'b0;
               state_next.step      = S_WB;
            end
            S_WB:
            begin
               state_next.mem_waddr = state_reg.cur_addr;
               state_next.mem_wdata = state_reg.data_word;
               state_next.mem_we    = 1'b1;
               state_next.step      = S_DECODE;
            end
            S_DECODE:
            begin
               if (is_jump && !autoidx)
               begin
                  // Address register through the second operand mux, relative field added, or subtracted when bit 5 is set.
                  state_next.pc = add_word(state_reg.cur_addr, rel_addr(state_reg.instr),
                                           bit5, 1'b0);
                  if (!state_reg.indirect_latch && !state_reg.tw)
                  begin
                     state_next.done = 1'b1;
                  end
                  state_next.step = S_PULSE_7;
               end
               else if (autoidx)
               begin
                  state_next.indirect_latch          = 1'b1;
                  state_next.indirect_flipflop_latch = 1'b1;
                  state_next.step                    = S_BP5;
               end
               else if (is_subr)
               begin
                  state_next.phase = PH_EXEC;
                  state_next.step  = S_EP0;
               end
               else
               begin
                  state_next.err  = 1'b1;
                  state_next.step = S_IDLE;
               end
            end
            S_BP5:
            begin
               state_next.autoindex_locator_latch = 1'b1;
               state_next.phase = PH_BASIC2;
               // Only addition is possible, so the last word comes from all ones plus zero.
               state_next.cur_addr = add_word(mx_val, rel_addr(state_reg.instr),
                                              1'b0, 1'b0);
               state_next.step  = S_PTR;
            end
            S_PTR:
            begin
               state_next.indirect_latch = 1'b0;
               state_next.buf_word  = mem_rd(state_reg.cur_addr);
               state_next.data_word = add_word(mem_rd(state_reg.cur_addr), ZERO_WORD,
                                               1'b0, 1'b1);
               state_next.mem_waddr = state_reg.cur_addr;
               state_next.step = S_PTRWB;
            end
            S_PTRWB:
            begin
               state_next.mem_wdata = state_reg.data_word;
               state_next.mem_we    = 1'b1;
               // The field bits live outside this 12-bit word, so the operand stays in field.
               state_next.cur_addr  = state_reg.data_word;
               state_next.autoindex_locator_latch = 1'b0;
               if (is_jump)
               begin
                  state_next.pc   = state_reg.data_word;
                  state_next.step = S_PULSE_7;
               end
               else
               begin
                  state_next.phase = PH_EXEC;
                  state_next.step  = is_subr ? S_EXEC_PERIOD_3 : S_EXEC_PERIOD_6;
               end
            end
            S_EP0:
            begin
               state_next.cur_addr = add_word(state_reg.cur_addr, rel_addr(state_reg.instr),
                                              bit5, 1'b0);
               state_next.pc = 12'(state_reg.pc + 12'h001);
               state_next.step = S_EXEC_PERIOD_3;
            end
            S_EXEC_PERIOD_3:
            begin
               state_next.data_word = add_word(state_reg.pc, ZERO_WORD, 1'b0, 1'b0);
               state_next.step      = S_EP5;
            end
            S_EP5:
            begin
               state_next.mem_waddr = state_reg.cur_addr;
               state_next.mem_wdata = state_reg.data_word;
               state_next.mem_we    = 1'b1;
               state_next.step      = S_EXEC_PERIOD_6;
            end
            S_EXEC_PERIOD_6:
            begin
               if (is_subr)
               begin
                  state_next.pc = add_word(state_reg.cur_addr, ZERO_WORD,
                                           1'b0, 1'b1);
               end
               state_next.done = 1'b1;
               state_next.step = S_PULSE_7;
            end
            S_PULSE_7:
            begin
               if (state_reg.done || state_reg.tw || state_reg.indirect_latch
                   || state_reg.exec_cond)
               begin
                  state_next.basic_phase_latch = 1'b1;
               end
               state_next.indirect_flipflop_latch = 1'b0;
               state_next.phase = PH_IDLE;
               state_next.step  = S_IDLE;
            end
            default:
            begin
               state_next.step = S_IDLE;
            end
         endcase
      end

      // APB slave: access phase with one wait state.
      if (apb_req.psel && apb_req.penable && !state_reg.rsp.pready)
      begin
         state_next.rsp.pready = 1'b1;
         unique case (apb_req.paddr)
            CTRL_OFF:
            begin
               if (apb_req.pwrite && state_reg.step == S_IDLE && apb_req.pwdata[CTRL_GO_BIT])
               begin
                  state_next.tw    = apb_req.pwdata[CTRL_TW_BIT];
                  state_next.exec_cond = apb_req.pwdata[CTRL_XCT_BIT];
                  state_next.basic_phase_latch = 1'b0;
                  state_next.err   = 1'b0;
                  state_next.phase = PH_BASIC1;
                  state_next.step  = S_FETCH;
                  state_next.tick  = 8'h00;
               end
            end
            PC_OFF:
            begin
               if (apb_req.pwrite && state_reg.step == S_IDLE)
               begin
                  state_next.pc = apb_req.pwdata[11:0];
               end
               state_next.rsp.prdata = {20'h0_0000, state_reg.pc};
            end
            INSTR_OFF:
            begin
               state_next.rsp.prdata = {20'h0_0000, state_reg.instr};
            end
            STATUS_OFF:
            begin
               state_next.rsp.prdata = {24'h00_0000, 1'b0, state_reg.err,
                                        state_reg.basic_phase_latch,
                                        state_reg.autoindex_locator_latch,
                                        state_reg.indirect_flipflop_latch,
                                        state_reg.indirect_latch,
                                        state_reg.done, state_reg.step != S_IDLE};
            end
            ADDR_OFF:
            begin
               if (apb_req.pwrite)
               begin
                  state_next.sw_addr = apb_req.pwdata[11:0];
               end
               state_next.rsp.prdata = {20'h0_0000, state_reg.sw_addr};
            end
            DATA_OFF:
            begin
               if (apb_req.pwrite && state_reg.step == S_IDLE)
               begin
                  state_next.mem_waddr = state_reg.sw_addr;
                  state_next.mem_wdata = apb_req.pwdata[11:0];
                  state_next.mem_we    = 1'b1;
               end
               state_next.rsp.prdata = {20'h0_0000, mem_rd(state_reg.sw_addr)};
            end
            default:
            begin
               state_next.rsp.pslverr = 1'b1;
            end
         endcase
      end
      state_next.busy = state_next.step != S_IDLE;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= '0;
         state_reg.pc <= PC_RESET;
         state_reg.step <= S_IDLE;
         state_reg.phase <= PH_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // Memory words are cleared only by software; no reset keeps the array small.
   always_ff @(posedge pclk)
   begin
      if (state_reg.mem_we)
      begin
         mem_reg[state_reg.mem_waddr[3:0]] <= state_reg.mem_wdata;
      end
   end

   assign apb_rsp  = state_reg.rsp;
   assign pc_out   = state_reg.pc;
   assign busy_out = state_reg.busy;
endmodule

/* common/jsaseq_pkg.sv */
/*
   Constants, enumerations and carrier types for the jump, jump-to-subroutine
   and auto-index sequencer of a 12-bit processor.
   Assumes one 200 MHz clock and an APB register port with 32-bit data.
*/
package jsaseq_pkg;
   localparam int          WORD_W        = 12;
   localparam int          FIELD_W       = 2;
   localparam int          ADDR_W        = 14;
   // Register byte offsets.
   localparam logic [7:0]  CTRL_OFF      = 8'h00;
   localparam logic [7:0]  INSTR_OFF     = 8'h04;
   localparam logic [7:0]  PC_OFF        = 8'h08;
   localparam logic [7:0]  STATUS_OFF    = 8'h0C;
   localparam logic [7:0]  ADDR_OFF      = 8'h10;
   localparam logic [7:0]  DATA_OFF      = 8'h14;
   // Control and status fields.
   localparam int          CTRL_GO_BIT   = 0;
   localparam int          CTRL_TW_BIT   = 1;
   localparam int          CTRL_XCT_BIT  = 2;
   localparam int          ST_BUSY_BIT   = 0;
   localparam int          ST_DONE_BIT   = 1;
   localparam int          ST_INDIR_BIT  = 2;
   localparam int          ST_INDFLOP_BIT = 3;
   localparam int          ST_LOC_BIT    = 4;
   localparam int          ST_BASIC_BIT  = 5;
   localparam int          ST_ERR_BIT    = 6;
   localparam logic [11:0] PC_RESET      = 12'h000;
   localparam logic [11:0] ALL_ONES      = 12'hFFF;
   localparam logic [11:0] ZERO_WORD     = 12'h000;
   // Instruction fields: bits numbered 0 (msb) to 11 (lsb).
   localparam logic [3:0]  OP_JUMP       = 4'hC;
   localparam logic [3:0]  OP_SUBR       = 4'hD;
   localparam logic [7:0]  OP_TW_SUBR    = 8'h1A;
   localparam int          BIT4_POS      = 7;
   localparam int          BIT5_POS      = 6;
   // Memory emulation timing: the memory cycle is 2 us.
   localparam int          CLK_MHZ       = 200;
   localparam int          MEM_CYCLE_NS  = 2000;
   localparam int          PERIOD_CYCLES = (MEM_CYCLE_NS * CLK_MHZ / 1000) / 8;

   typedef enum logic [1:0] {PH_BASIC1, PH_BASIC2, PH_EXEC, PH_IDLE} jsaseq_phase_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } jsaseq_apb_rsp_t;

   typedef struct packed {
      logic        paddr_ok;
      logic [7:0]  paddr;
      logic        pwrite;
      logic [31:0] pwdata;
      logic        psel;
      logic        penable;
   } jsaseq_apb_req_t;
endpackage

/* testbench/jsaseq_core_asserts.sv */
/* Checker for the APB port, program counter and busy flag of jsaseq_core.
   Assumes it is bound to jsaseq_core and sees only that module's ports. */
`timescale 1ns/100ps
module jsaseq_core_asserts
   import jsaseq_pkg::*;
(
   input wire logic                        pclk,
   input wire logic                        presetn,
   input wire jsaseq_pkg::jsaseq_apb_req_t apb_req,
   input wire jsaseq_pkg::jsaseq_apb_rsp_t apb_rsp,
   input wire logic [11:0]                 pc_out,
   input wire logic                        busy_out
);
   // ********************
   // Helper logic
   // ********************
   logic        access;
   logic        mapped;
   logic        go_wr;
   logic        pc_wr;
   logic [10:0] busy_cnt_reg;
   logic [10:0] busy_cnt_next;
   assign access = apb_req.psel && apb_req.penable;
   assign mapped = apb_req.paddr inside {CTRL_OFF, INSTR_OFF, PC_OFF, STATUS_OFF, ADDR_OFF,
                                         DATA_OFF};
   assign go_wr  = access && apb_req.pwrite && apb_req.paddr == CTRL_OFF
                   && apb_req.pwdata[CTRL_GO_BIT];
   assign pc_wr  = access && apb_req.pwrite && apb_req.paddr == PC_OFF;
   // The counter saturates nowhere; a sequence that never ends trips busy_bound_a first.
   always_comb busy_cnt_next = busy_out ? busy_cnt_reg + 11'h001 : 11'h000;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         busy_cnt_reg <= 11'h000;
      else
         busy_cnt_reg <= busy_cnt_next;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ********************
   // Assertions
   // ********************
   pready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready stood longer than one cycle");
   answer_time_a: assert property (access && !apb_rsp.pready |=> apb_rsp.pready)
      else $error("pready did not follow the first access cycle");
   ready_cause_a: assert property (apb_rsp.pready |-> access && $past(access))
      else $error("pready without an access phase");
   err_pairing_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
      else $error("pslverr outside pready");
   unmapped_err_a: assert property (apb_rsp.pready && !mapped |-> apb_rsp.pslverr)
      else $error("unmapped offset answered without error");
   mapped_ok_a: assert property (apb_rsp.pready && mapped |-> !apb_rsp.pslverr)
      else $error("mapped offset answered with error");
   read_upper_a: assert property (apb_rsp.pready && !apb_req.pwrite
                                  |-> apb_rsp.prdata[31:12] == 20'h0_0000)
      else $error("upper read data bits not zero");
   busy_cause_a: assert property ($rose(busy_out) |-> $past(go_wr) || $past(go_wr, 2))
      else $error("busy rose without a go write");
   pc_cause_a: assert property ($changed(pc_out) |->
                                busy_out || $past(busy_out) || $past(pc_wr) || $past(pc_wr, 2))
      else $error("program counter moved while idle");
   busy_bound_a: assert property (busy_cnt_reg < 11'd1500)
      else $error("sequence ran too long");
endmodule

bind jsaseq_core jsaseq_core_asserts u_asserts (.pclk(pclk), .presetn(presetn),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .pc_out(pc_out), .busy_out(busy_out));

/* testbench/jsaseq_mem_model.sv */
/* Expected image of the 16-word memory field behind the sequencer.
   Assumes the bench mirrors every load into it and applies each documented change. */
`timescale 1ns/100ps
module jsaseq_mem_model;
   logic [11:0] words [16];
   // A jump fetch writes the word back unchanged, so it needs no update here.
   task automatic store_return(input logic [11:0] ea, input logic [11:0] pc);
      words[ea[3:0]] = pc + 12'h001;
   endtask
   // Pointers at both field ends alias to entries 0 and 15, inside the same field.
   task automatic bump(input logic [3:0] p);
      words[p] = words[p] + 12'h001;
   endtask
endmodule

/* testbench/jsaseq_tb_top.sv */
/* Self-checking bench for jsaseq_core: jumps, subroutine jumps and auto-index.
   Assumes APB access to the memory field and a 200 MHz pclk. */
`timescale 1ns/100ps
module jsaseq_tb_top;
   import jsaseq_pkg::*;
   logic            pclk;
   logic            presetn;
   jsaseq_apb_req_t apb_req;
   jsaseq_apb_rsp_t apb_rsp;
   logic [11:0]     pc_out;
   logic            busy_out;
   logic [31:0]     rdat;
   logic            rerr;
   int              miscompares = 0;
   int              compares = 0;
   int              cycles = 0;

   jsaseq_core dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
                    .pc_out(pc_out), .busy_out(busy_out));
   jsaseq_mem_model mem ();

   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         miscompares = miscompares + 1;
         end_of_test();
      end
   end

   // ********************
   // Shared tasks
   // ********************
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Requests change only after an edge and hold until pready is sampled high.
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
      @(posedge pclk);
      apb_req <= '{paddr_ok:1'b0, paddr:addr, pwrite:wr, pwdata:wd, psel:1'b1, penable:1'b0};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do
         @(posedge pclk);
      while (apb_rsp.pready !== 1'b1);
      rdat = apb_rsp.prdata;
      rerr = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask
   task automatic poke(input logic [3:0] i, input logic [11:0] v);
      apb(1'b1, ADDR_OFF, 32'(i));
      apb(1'b1, DATA_OFF, 32'(v));
      mem.words[i] = v;
   endtask
   task automatic run(input logic [11:0] pc, input logic [31:0] ctrl = 32'h0000_0001);
      apb(1'b1, PC_OFF, 32'(pc));
      apb(1'b1, CTRL_OFF, ctrl);
      for (int n = 0; n < 4 && busy_out !== 1'b1; n++)
         @(posedge pclk);
      check("busy", 32'(busy_out), 32'h0000_0001);
      while (busy_out !== 1'b0)
         @(posedge pclk);
   endtask
   task automatic check_mem();
      for (int i = 0; i < 16; i++)
      begin
         apb(1'b1, ADDR_OFF, 32'(i));
         apb(1'b0, DATA_OFF, 32'h0000_0000);
         check("memory word", rdat, 32'(mem.words[i]));
      end
   endtask

   // ********************
   // Scenarios
   // ********************
   task automatic test_regs();
      check("pc after reset", 32'(pc_out), 32'h0000_0000);
      apb(1'b0, 8'h18, 32'h0000_0000);
      check("unmapped error", 32'(rerr), 32'h0000_0001);
      apb(1'b0, PC_OFF, 32'h0000_0000);
      check("pc read", rdat, 32'h0000_0000);
   endtask
   task automatic test_jump();
      poke(4'h2, 12'hC03);
      run(12'h002);
      check("jump forward pc", 32'(pc_out), 32'h0000_0005);
      apb(1'b0, STATUS_OFF, 32'h0000_0000);
      check("done latch", 32'(rdat[ST_DONE_BIT]), 32'h0000_0001);
      check("basic phase latch", 32'(rdat[ST_BASIC_BIT]), 32'h0000_0001);
      poke(4'h9, 12'hC43);
      run(12'h009);
      check("jump backward pc", 32'(pc_out), 32'h0000_0006);
      poke(4'h1, 12'hC00);
      run(12'h001);
      check("direct jump pc", 32'(pc_out), 32'h0000_0001);
      run(12'h002, 32'h0000_0003);
      check("two-word jump pc", 32'(pc_out), 32'h0000_0005);
      apb(1'b0, STATUS_OFF, 32'h0000_0000);
      check("two-word done", 32'(rdat[ST_DONE_BIT]), 32'h0000_0000);
      check("two-word basic phase", 32'(rdat[ST_BASIC_BIT]), 32'h0000_0001);
      poke(4'h6, 12'h006);
      run(12'h006);
      apb(1'b0, STATUS_OFF, 32'h0000_0000);
      check("unknown opcode error", 32'(rdat[ST_ERR_BIT]), 32'h0000_0001);
      check_mem();
   endtask
   task automatic test_subroutine();
      poke(4'h3, 12'hD04);
      run(12'h003);
      mem.store_return(12'h007, 12'h003);
      check("subroutine pc", 32'(pc_out), 32'h0000_0008);
      poke(4'hC, 12'hD42);
      run(12'h00C);
      mem.store_return(12'h00A, 12'h00C);
      check("subroutine back pc", 32'(pc_out), 32'h0000_000B);
      check_mem();
   endtask
   task automatic test_autoindex();
      poke(4'h0, 12'h009);
      poke(4'h4, 12'hC80);
      run(12'h004);
      mem.bump(4'h0);
      check("first pointer pc", 32'(pc_out), 32'h0000_000A);
      poke(4'hF, 12'h002);
      poke(4'h5, 12'hCC0);
      run(12'h005);
      mem.bump(4'hF);
      check("last pointer pc", 32'(pc_out), 32'h0000_0003);
      check_mem();
   endtask

   initial
   begin
      apb_req = '0;
      presetn = 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      test_regs();
      for (int i = 0; i < 16; i++)
         poke(4'(i), 12'h100 + 12'(i));
      test_jump();
      test_subroutine();
      test_autoindex();
      end_of_test();
   end
endmodule
